// file: rtl/rtbt_pkg.sv
// rtbt_pkg: shared constants for the real-time bus trace buffer
// assumes: single clock domain, used by rtbt_top and rtbt_wait_gen
package rtbt_pkg;
  // trace word field widths
  localparam int ADDR_W  = 16;
  localparam int DATA_W  = 16;
  localparam int PROBE_W = 8;
  localparam int CTYPE_W = 3;
  localparam int TAG_W   = 5;
  localparam int WORD_W  = ADDR_W + DATA_W + PROBE_W + CTYPE_W + TAG_W;  // 48
  // channels sampled for an 8-bit data bus processor
  localparam int CHANNELS = ADDR_W + 8 + PROBE_W + CTYPE_W + TAG_W - 0;  // 40 + wait/ctl
  localparam int DEPTH_DEF = 128;
  // field positions inside the trace word
  localparam int TAG_LSB   = 0;
  localparam int CTYPE_LSB = TAG_LSB + TAG_W;
  localparam int PROBE_LSB = CTYPE_LSB + CTYPE_W;
  localparam int DATA_LSB  = PROBE_LSB + PROBE_W;
  localparam int ADDR_LSB  = DATA_LSB + DATA_W;
  // cycle type codes
  localparam logic [2:0] CT_MEM_RD = 3'h0;
  localparam logic [2:0] CT_MEM_WR = 3'h1;
  localparam logic [2:0] CT_IO_RD  = 3'h2;
  localparam logic [2:0] CT_IO_WR  = 3'h3;
  localparam logic [2:0] CT_FETCH  = 3'h4;
  // trigger position modes
  localparam logic [1:0] POS_PRE    = 2'h0;  // words before trigger
  localparam logic [1:0] POS_CENTER = 2'h1;  // variable centre
  localparam logic [1:0] POS_POST   = 2'h2;  // words after trigger
  // tag carried after start and stop
  localparam logic [4:0] TAG_RESET = 5'h00;
  localparam logic [4:0] TAG_STOP_FLAG = 5'h10;  // msb marks stop, low bits count starts
  // wait states per machine cycle while software breakpoints are armed and no analyzer is present
  localparam int WAIT_STATES = 1;
  typedef enum {ST_IDLE, ST_ARMED, ST_POST, ST_FROZEN} rtbt_state_e;
endpackage

// file: rtl/rtbt_wait_gen.sv
// rtbt_wait_gen: per machine cycle wait-state request for the emulator
// assumes: cycle_start_i pulses once at the start of each machine cycle
module rtbt_wait_gen
  import rtbt_pkg::*;
#(
  parameter int WAITS = WAIT_STATES
) (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  // control
  input  wire logic enable_i,
  input  wire logic cycle_start_i,
  input  wire logic ready_clk_i,
  // wait request to processor
  output logic      wait_o
);
  // elaboration check of the wait count
  if (WAITS < 1 || WAITS > 15) begin : g_bad_waits
    $error("rtbt_wait_gen: WAITS out of range");
  end

  logic [3:0] cnt;
  logic [3:0] next_cnt;

  // count wait states still owed this machine cycle
  // owed waits are dropped once breakpoints disarm or the analyzer takes over
  always_comb begin
    next_cnt = cnt;
    if (!enable_i) begin
      next_cnt = 4'h0;
    end else if (cycle_start_i) begin
      next_cnt = 4'(WAITS);
    end else if (ready_clk_i && cnt != 4'h0) begin
      next_cnt = cnt - 4'h1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 4'h0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign wait_o = (cnt != 4'h0);
endmodule

// file: rtl/rtbt_top.sv
// rtbt_top: real-time bus trace capture with DEPTH-word circular buffer, 128 words by default
// assumes: bus_cycle_i pulses once per emulated bus cycle, sync to clk_sys_i
module rtbt_top
  import rtbt_pkg::*;
#(
  parameter int DEPTH  = DEPTH_DEF,
  parameter int DWIDTH = 8
) (
  // clock and reset
  input  wire logic                     clk_sys_i,
  input  wire logic                     rst_n_i,
  // emulated processor bus
  input  wire logic                     bus_cycle_i,
  input  wire logic                     machine_cycle_i,
  input  wire logic                     ready_clk_i,
  input  wire logic [ADDR_W-1:0]        addr_i,
  input  wire logic [DATA_W-1:0]        data_i,
  input  wire logic [CTYPE_W-1:0]       cycle_type_i,
  input  wire logic                     running_i,
  // prototype probe
  input  wire logic [PROBE_W-1:0]       probe_i,
  // debug control
  input  wire logic                     analyzer_present_i,
  input  wire logic                     software_breakpoint_i,
  input  wire logic                     analyzer_event_trigger_i,
  input  wire logic [1:0]               trig_pos_i,
  input  wire logic [$clog2(DEPTH)-1:0] center_after_i,
  input  wire logic                     arm_i,
  // trace readout
  input  wire logic [$clog2(DEPTH)-1:0] rd_idx_i,
  output logic      [WORD_W-1:0]        rd_word_o,
  output logic      [$clog2(DEPTH):0]   fill_o,
  output logic      [$clog2(DEPTH)-1:0] oldest_o,
  output logic                          frozen_o,
  output logic                          triggered_o,
  output logic                          break_req_o,
  // wait request to processor
  output logic                          wait_o
);
  localparam int AW = $clog2(DEPTH);

  // elaboration checks of the parameters
  if (DEPTH < 2 || DEPTH > DEPTH_DEF) begin : g_bad_depth
    $error("rtbt_top: DEPTH must be 2..128");
  end
  if (DWIDTH != 8 && DWIDTH != 16) begin : g_bad_dwidth
    $error("rtbt_top: DWIDTH must be 8 or 16");
  end

  // trace store
  logic [WORD_W-1:0] mem [DEPTH];

  rtbt_state_e state;
  rtbt_state_e next_state;
  logic [AW-1:0]   wptr;
  logic [AW-1:0]   next_wptr;
  logic [AW:0]     fill;
  logic [AW:0]     next_fill;
  logic [AW:0]     post_left;
  logic [AW:0]     next_post_left;
  logic [TAG_W-1:0] tag;
  logic [TAG_W-1:0] next_tag;
  logic            run_q;
  logic            trig_q;
  logic            next_trig;
  logic [WORD_W-1:0] rd_word;
  logic [WORD_W-1:0] word;
  logic [DATA_W-1:0] data_cap;
  logic            capture;

  // data field narrowed for an 8-bit processor
  // data bus width
  assign data_cap = (DWIDTH == 8) ? {8'h00, data_i[7:0]} : data_i;

  // assemble word, all channels from the same cycle
  // address field
  assign word = {addr_i, data_cap, probe_i, cycle_type_i, tag};

  // no word once the post-trigger count is spent, else the oldest is overwritten
  // capture per cycle
  assign capture = bus_cycle_i && running_i &&
                   (state == ST_ARMED || (state == ST_POST && post_left != '0));

  // tag tracks processor starts and stops
  always_comb begin
    next_tag = tag;
    if (running_i && !run_q) begin
      next_tag = {1'b0, tag[3:0] + 4'h1};
    end else if (!running_i && run_q) begin
      next_tag = tag | TAG_STOP_FLAG;
    end
  end

  // trigger state machine and pointers
  always_comb begin
    next_state     = state;
    next_wptr      = wptr;
    next_fill      = fill;
    next_post_left = post_left;
    next_trig      = trig_q;
    case (state)
      ST_IDLE: begin
        if (arm_i) begin
          next_state = ST_ARMED;
          next_wptr  = '0;
          next_fill  = '0;
          next_trig  = 1'b0;
        end
      end
      ST_ARMED: begin
        if (capture) begin
          next_wptr = (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
          if (fill != (AW+1)'(DEPTH)) next_fill = fill + 1'b1;
        end
        if (analyzer_event_trigger_i && analyzer_present_i) begin
          next_trig = 1'b1;
          case (trig_pos_i)
            POS_PRE:    next_post_left = '0;
            POS_CENTER: next_post_left = {1'b0, center_after_i};
            POS_POST:   next_post_left = (AW+1)'(DEPTH);
            default:    next_post_left = '0;
          endcase
          next_state = ST_POST;
        end
      end
      ST_POST: begin
        if (post_left == '0) begin
          next_state = ST_FROZEN;
        end else if (capture) begin
          next_wptr = (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
          if (fill != (AW+1)'(DEPTH)) next_fill = fill + 1'b1;
          next_post_left = post_left - 1'b1;
        end
      end
      ST_FROZEN: begin
        if (arm_i) next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
    // a trigger in POS_PRE freezes without any further word
    if (state == ST_POST && post_left == '0) next_state = ST_FROZEN;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state     <= ST_IDLE;
      wptr      <= '0;
      fill      <= '0;
      post_left <= '0;
      tag       <= TAG_RESET;
      run_q     <= 1'b0;
      trig_q    <= 1'b0;
    end else begin
      state     <= next_state;
      wptr      <= next_wptr;
      fill      <= next_fill;
      post_left <= next_post_left;
      tag       <= next_tag;
      run_q     <= running_i;
      trig_q    <= next_trig;
    end
  end

  // trace store write and registered readout
  // single-cycle sample, no stall
  always_ff @(posedge clk_sys_i) begin
    if (capture) mem[wptr] <= word;
  end

  always_comb begin
    rd_word = mem[rd_idx_i];
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_word_o <= '0;
    end else begin
      rd_word_o <= rd_word;
    end
  end

  // oldest entry: write pointer once wrapped, else zero
  assign fill_o      = fill;
  assign oldest_o    = (fill == (AW+1)'(DEPTH)) ? wptr : '0;
  assign frozen_o    = (state == ST_FROZEN);
  assign triggered_o = trig_q;

  assign break_req_o = analyzer_present_i && analyzer_event_trigger_i;

  rtbt_wait_gen #(
    .WAITS (WAIT_STATES)
  ) u_wait (
    .clk_sys_i     (clk_sys_i),
    .rst_n_i       (rst_n_i),
    .enable_i      (software_breakpoint_i && !analyzer_present_i),
    .cycle_start_i (machine_cycle_i),
    .ready_clk_i   (ready_clk_i),
    .wait_o        (wait_o)
  );
endmodule

// file: verification/rtbt_top_sva.sv
// rtbt_top_sva: port checks of the trace capture and wait logic
// assumes: bound to every rtbt_top, one clock domain
module rtbt_top_sva
  import rtbt_pkg::*;
#(
  parameter int DEPTH = DEPTH_DEF
) (
  // clock and reset
  input wire logic                   clk_sys_i,
  input wire logic                   rst_n_i,
  // stimulus seen by the block
  input wire logic                   machine_cycle_i,
  input wire logic                   ready_clk_i,
  input wire logic                   running_i,
  input wire logic                   analyzer_present_i,
  input wire logic                   software_breakpoint_i,
  input wire logic                   analyzer_event_trigger_i,
  input wire logic                   arm_i,
  input wire logic [1:0]             trig_pos_i,
  // block outputs
  input wire logic [$clog2(DEPTH):0] fill_o,
  input wire logic                   frozen_o,
  input wire logic                   triggered_o,
  input wire logic                   wait_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  fill_max_a: assert property (fill_o <= DEPTH)
    else $error("fill above depth");
  fill_step_a: assert property (fill_o > $past(fill_o) |-> fill_o == $past(fill_o) + 1'b1)
    else $error("fill jumped");
  stop_hold_a: assert property (!running_i && !arm_i |=> $stable(fill_o))
    else $error("capture while stopped");
  freeze_hold_a: assert property (frozen_o && !arm_i |=> frozen_o && $stable(fill_o))
    else $error("frozen buffer changed");
  pre_freeze_a: assert property ($rose(triggered_o) && trig_pos_i == POS_PRE |-> ##[0:2] frozen_o)
    else $error("pre mode did not freeze");
  trig_gate_a: assert property (!triggered_o && !(analyzer_event_trigger_i && analyzer_present_i)
    |=> !triggered_o) else $error("trigger without event");
  wait_set_a: assert property (machine_cycle_i && software_breakpoint_i && !analyzer_present_i
    |=> wait_o) else $error("wait state missing");
  wait_clr_a: assert property (wait_o && ready_clk_i && !machine_cycle_i |=> !wait_o)
    else $error("wait state too long");
  full_speed_a: assert property (analyzer_present_i && $past(analyzer_present_i) |-> !wait_o)
    else $error("wait with analyzer");
  no_stall_a: assert property (!software_breakpoint_i |=> !wait_o)
    else $error("wait without breakpoint");
  // main scenarios reached
  cover property ($rose(frozen_o));
  cover property ($rose(wait_o));
  cover property (fill_o == DEPTH);
endmodule

bind rtbt_top rtbt_top_sva #(.DEPTH(DEPTH)) chk (.clk_sys_i, .rst_n_i, .machine_cycle_i,
  .ready_clk_i, .running_i, .analyzer_present_i, .software_breakpoint_i,
  .analyzer_event_trigger_i, .arm_i, .trig_pos_i, .fill_o, .frozen_o, .triggered_o, .wait_o);

// file: verification/rtbt_proc_model.sv
// rtbt_proc_model: emulated processor bus and probe lines
// assumes: one bus cycle per cyc call, clocked by the bench clock
module rtbt_proc_model
  import rtbt_pkg::*;
(
  input  wire logic          clk_sys_i,
  output logic               bus_cycle_o,
  output logic [ADDR_W-1:0]  addr_o,
  output logic [DATA_W-1:0]  data_o,
  output logic [CTYPE_W-1:0] cycle_type_o,
  output logic [PROBE_W-1:0] probe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // quiet bus at time zero
  initial begin
    bus_cycle_o = 1'b0;
    addr_o = 16'h0;
    data_o = 16'h0;
    cycle_type_o = 3'h0;
    probe_o = 8'h0;
  end
  // one bus cycle, address and data lines flip after it so stale values never match
  task automatic cyc(input logic [15:0] a, d, input logic [2:0] t, input logic [7:0] p, int gap);
    @(posedge clk_sys_i);
    bus_cycle_o <= 1'b1;
    addr_o <= a;
    data_o <= d;
    cycle_type_o <= t;
    probe_o <= p;
    @(posedge clk_sys_i);
    bus_cycle_o <= 1'b0;
    addr_o <= ~a;
    data_o <= ~d;
    repeat (gap) @(posedge clk_sys_i);
  endtask
endmodule

// file: verification/realtime_bus_trace_buffer_tb.sv
// realtime_bus_trace_buffer_tb: self-checking bench for rtbt_top
// assumes: rtbt_proc_model drives the bus, checker bound by its own file
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
  $display("ERROR %0t: got %h expected %h", $time, a, e); end end
module realtime_bus_trace_buffer_tb
  import rtbt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i, rst_n_i, machine_cycle_i, ready_clk_i, running_i, arm_i;
  logic analyzer_present_i, software_breakpoint_i, analyzer_event_trigger_i;
  logic bus_cycle_i, frozen_o, triggered_o, wait_o, break_req_o;
  logic [47:0] exp_word;
  logic [15:0] addr_i, data_i;
  logic [7:0]  probe_i, fill_o;
  logic [6:0]  center_after_i, rd_idx_i, oldest_o;
  logic [2:0]  cycle_type_i;
  logic [1:0]  trig_pos_i;
  logic [47:0] rd_word_o;
  int          fails, check_count;
  // design and bus model
  rtbt_top #(.DEPTH(128), .DWIDTH(8)) dut (.clk_sys_i, .rst_n_i, .bus_cycle_i, .machine_cycle_i,
    .ready_clk_i, .addr_i, .data_i, .cycle_type_i, .running_i, .probe_i, .analyzer_present_i,
    .software_breakpoint_i, .analyzer_event_trigger_i, .trig_pos_i, .center_after_i, .arm_i,
    .rd_idx_i, .rd_word_o, .fill_o, .oldest_o, .frozen_o, .triggered_o, .break_req_o, .wait_o);
  rtbt_proc_model proc (.clk_sys_i, .bus_cycle_o(bus_cycle_i), .addr_o(addr_i),
    .data_o(data_i), .cycle_type_o(cycle_type_i), .probe_o(probe_i));
  // clock
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // verdict and end of run
  task final_report;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task arm;
    @(posedge clk_sys_i) arm_i <= 1'b1;
    @(posedge clk_sys_i) arm_i <= 1'b0;
  endtask
  // five cycle types captured and read back field by field
  task t_fields;
    arm();
    @(posedge clk_sys_i) running_i <= 1'b1;
    for (int i = 0; i < 5; i++) proc.cyc(16'h1000 + 16'(i) * 16'h111, 16'hA5C0 + 16'(i),
      3'(i), 8'h80 >> i, i);
    #1 `CHK(fill_o, 8'd5)
    `CHK(wait_o, 1'b0)
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_sys_i) rd_idx_i <= oldest_o + 7'(i);
      @(posedge clk_sys_i) #1;
      exp_word = {16'h1000 + 16'(i) * 16'h111, 8'h00, 8'hC0 + 8'(i), 8'h80 >> i, 3'(i), 5'h01};
      `CHK(rd_word_o, exp_word)
    end
    $display("fields done");
  endtask
  // stopped processor adds nothing, then wrap past 128
  task t_stop_wrap;
    @(posedge clk_sys_i) running_i <= 1'b0;
    proc.cyc(16'h0, 16'h0, CT_MEM_RD, 8'h0, 0);
    #1 `CHK(fill_o, 8'd5)
    @(posedge clk_sys_i) running_i <= 1'b1;
    repeat (130) proc.cyc(16'h3000, 16'h0011, CT_MEM_WR, 8'h0F, 0);
    #1 `CHK(fill_o, 8'd128)
    `CHK(oldest_o, 7'd7)
    $display("stop and wrap done");
  endtask
  // trigger position decides how many words follow the trigger
  task t_trig(input logic [1:0] m, input int k, input logic [6:0] o);
    @(posedge clk_sys_i) trig_pos_i <= m;
    analyzer_present_i <= 1'b1;
    if (frozen_o) arm();
    arm();
    repeat (10) proc.cyc(16'h2000, 16'h0, CT_FETCH, 8'h0, 0);
    @(posedge clk_sys_i) analyzer_event_trigger_i <= 1'b1;
    #1 `CHK(break_req_o, 1'b1)
    @(posedge clk_sys_i) analyzer_event_trigger_i <= 1'b0;
    #1 `CHK(triggered_o, 1'b1)
    repeat (140) proc.cyc(16'h2100, 16'h0, CT_IO_RD, 8'h0, 0);
    #1 `CHK(fill_o, 8'(k + 10 > 128 ? 128 : k + 10))
    `CHK(frozen_o, 1'b1)
    `CHK(oldest_o, o)
    $display("trigger mode %0d done", m);
  endtask
  // one wait state without analyzer, none with it
  task t_wait;
    @(posedge clk_sys_i) analyzer_present_i <= 1'b0;
    software_breakpoint_i <= 1'b1;
    @(posedge clk_sys_i) machine_cycle_i <= 1'b1;
    analyzer_event_trigger_i <= 1'b1;
    #1 `CHK(break_req_o, 1'b0)
    @(posedge clk_sys_i) machine_cycle_i <= 1'b0;
    analyzer_event_trigger_i <= 1'b0;
    #1 `CHK(wait_o, 1'b1)
    @(posedge clk_sys_i) ready_clk_i <= 1'b1;
    @(posedge clk_sys_i) ready_clk_i <= 1'b0;
    #1 `CHK(wait_o, 1'b0)
    @(posedge clk_sys_i) analyzer_present_i <= 1'b1;
    @(posedge clk_sys_i) machine_cycle_i <= 1'b1;
    @(posedge clk_sys_i) machine_cycle_i <= 1'b0;
    #1 `CHK(wait_o, 1'b0)
    $display("wait done");
  endtask
  // reset, then the scenarios in order
  initial begin
    {rst_n_i, machine_cycle_i, ready_clk_i, running_i, arm_i} = '0;
    {analyzer_present_i, software_breakpoint_i, analyzer_event_trigger_i} = '0;
    trig_pos_i = POS_PRE;
    center_after_i = 7'd4;
    rd_idx_i = 7'd0;
    repeat (10) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_fields();
    t_stop_wrap();
    t_trig(POS_POST, 128, 7'd17);
    t_trig(POS_PRE, 0, 7'd0);
    t_trig(POS_CENTER, 4, 7'd0);
    t_wait();
    final_report();
  end
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    fails++;
    final_report();
  end
endmodule
